// ==== design/eei2c_target.sv ====
// Two-wire serial memory target: bus engine, page buffer, array
// Notes on behaviour
// - Sample data on clock rise, change after fall
// - Data output only pulls low or releases
// - Respond only when select bits match pins
// - Floating select pins read as zero
// - Write protect high refuses all writes
// - Floating write protect reads as low
// - Variant without protect pin always allows writes
// - Ignore clock and data pulses up to 100ns
// - Reset on power loss, standby after power-up
// - Clock line is input only, never driven
// - Controller assigns roles; target follows requests
// - 1MHz operation only on later revision
// - Busy writing: release data, acknowledge nothing
// - Strobe protect before first data byte; nack
// - Variants without select pins answer zero only
`default_nettype none
module eei2c_target
  import eei2c_pkg::*;
#(
  parameter int unsigned PU_CYC        = POWERUP_READY_CYC,
  parameter int unsigned WR_CYC        = INTERNAL_WRITE_CYC,
  parameter bit          WP_PRESENT    = 1'b1,
  parameter bit          SEL_PRESENT   = 1'b1,
  parameter bit          FAST_PLUS_REV = 1'b1
) (
  // System clock and power-on reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Oversampling clock of the bus front end
  input  wire logic link_clk,
  // Bus pins
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  output logic      sda_o,
  output logic      sda_oe_n,
  // Strap and protect pins
  input  wire logic addr_select_bit0,
  input  wire logic addr_select_bit1,
  input  wire logic addr_select_bit2,
  input  wire logic wp_pin,
  // Status
  output logic      ready,
  output logic      write_busy
);
  localparam int unsigned DEPTH = 1 << ADDR_W;
  localparam int unsigned PW    = $clog2(PAGE_BYTES);
  localparam int unsigned PUW   = $clog2(PU_CYC + 1);
  localparam int unsigned WRW   = $clog2(WR_CYC + 1);
  localparam logic [7:0]  HOLD  =
    FAST_PLUS_REV ? 8'(OUT_HOLD_FP_CYC) : 8'(OUT_HOLD_CYC);

  if (PU_CYC < 1 || WR_CYC < 1 || ADDR_W <= 8 || ADDR_W > 16 ||
      PAGE_BYTES < 2 || (1 << PW) != PAGE_BYTES) begin : g_chk
    $error("eei2c_target: unsupported parameter values");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV  = 3'h1,
    ST_AHI  = 3'h2,
    ST_ALO  = 3'h3,
    ST_WDAT = 3'h4,
    ST_RDAT = 3'h5,
    ST_RACK = 3'h6,
    ST_IGN  = 3'h7
  } eei2c_st_t;

  typedef struct packed {
    eei2c_st_t                  st;
    logic [3:0]                 bitcnt;
    logic                       ackph;
    logic [7:0]                 sh;
    logic [7:0]                 tx;
    logic [ADDR_W-1:0]          addr;
    logic                       rw;
    logic                       macked;
    logic                       wp_blk;
    logic                       pend;
    logic [7:0]                 hcnt;
    logic                       sda_oe_n;
    logic                       sda_o;
    logic                       busy;
    logic [WRW-1:0]             wcnt;
    logic                       ready;
    logic [PUW-1:0]             pucnt;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0]      pmask;
    logic                       scl_q;
    logic                       sda_q;
  } eei2c_state_t;

  eei2c_state_t s;
  eei2c_state_t next_s;
  logic [7:0]   mem [DEPTH];

  // ****************************************************************
  // Bus front end and pin synchronisers
  // ****************************************************************
  logic       scl_f;
  logic       sda_f;
  logic       scl;
  logic       sda;
  logic [2:0] sel_pins;
  logic       wp_s;

  // Filtered on the oversampling clock
  eei2c_filter u_flt_scl (
    .link_clk (link_clk),
    .rst_n    (rst_n),
    .pin      (scl_pin),
    .level    (scl_f)
  );

  eei2c_filter u_flt_sda (
    .link_clk (link_clk),
    .rst_n    (rst_n),
    .pin      (sda_pin),
    .level    (sda_f)
  );

  eei2c_sync #(.W(2), .AGREE(1'b1), .RST(2'h3)) u_sync_bus (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({scl_f, sda_f}),
    .dout  ({scl, sda})
  );

  eei2c_sync #(.W(4), .AGREE(1'b1), .RST(4'h0)) u_sync_pins (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({addr_select_bit2, addr_select_bit1, addr_select_bit0,
             wp_pin}),
    .dout  ({sel_pins, wp_s})
  );

  // ****************************************************************
  // Bus engine
  // ****************************************************************
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic [2:0] sel;
  logic       wp_eff;
  logic       ok;
  logic       do_commit;
  logic [7:0] rd_byte;

  // Pull-downs resolve floating straps to zero
  assign sel    = SEL_PRESENT ? sel_pins : SEL_NO_PINS;
  assign wp_eff = WP_PRESENT ? wp_s : 1'b0;
  assign do_commit = s.busy && (s.wcnt == WRW'(1));
  assign rd_byte   = mem[s.addr];

  always_comb begin
    next_s       = s;
    ok           = 1'b0;
    scl_rise     = scl && !s.scl_q;
    scl_fall     = !scl && s.scl_q;
    start_c      = scl && s.scl_q && s.sda_q && !sda;
    stop_c       = scl && s.scl_q && !s.sda_q && sda;
    next_s.scl_q = scl;
    next_s.sda_q = sda;

    // Standby only after the power-up delay
    if (!s.ready) begin
      next_s.pucnt = s.pucnt - 1'b1;
      if (s.pucnt == PUW'(1)) begin
        next_s.ready = 1'b1;
      end
    end

    if (s.busy) begin
      next_s.wcnt = s.wcnt - 1'b1;
      if (do_commit) begin
        next_s.busy  = 1'b0;
        next_s.pmask = '0;
      end
    end

    // Output moves only after the falling-edge hold, except that start and stop release it at once
    if (s.hcnt != 8'h0) begin
      next_s.hcnt = s.hcnt - 8'h1;
      if (s.hcnt == 8'h1) begin
        next_s.sda_oe_n = s.pend;
      end
    end

    if (!s.ready) begin
      next_s.st = ST_IDLE;
    end else if (start_c) begin
      next_s.st       = ST_DEV;
      next_s.bitcnt   = 4'h0;
      next_s.ackph    = 1'b0;
      next_s.hcnt     = 8'h0;
      next_s.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      next_s.st       = ST_IDLE;
      next_s.hcnt     = 8'h0;
      next_s.sda_oe_n = 1'b1;
      next_s.wp_blk   = 1'b0;
      if (|s.pmask && !s.busy && !s.wp_blk) begin
        next_s.busy = 1'b1;
        next_s.wcnt = WRW'(WR_CYC);
      end else if (!s.busy) begin
        next_s.pmask = '0;
      end
    end else if (scl_rise) begin
      case (s.st)
        ST_DEV, ST_AHI, ST_ALO, ST_WDAT: begin
          if (!s.ackph && s.bitcnt < 4'h8) begin
            next_s.sh     = {s.sh[6:0], sda};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end
        end
        ST_RACK: next_s.macked = !sda;
        default: ;
      endcase
    end else if (scl_fall) begin
      // Roles come from the received direction bit
      case (s.st)
        ST_DEV, ST_AHI, ST_ALO, ST_WDAT: begin
          if (s.ackph) begin
            next_s.ackph  = 1'b0;
            next_s.bitcnt = 4'h0;
            next_s.pend   = 1'b1;
            next_s.hcnt   = HOLD;
            case (s.st)
              ST_DEV: begin
                if (s.rw) begin
                  next_s.st     = ST_RDAT;
                  next_s.tx     = rd_byte;
                  next_s.addr   = s.addr + 1'b1;
                  next_s.bitcnt = 4'h1;
                  next_s.pend   = rd_byte[7];
                end else begin
                  next_s.st = ST_AHI;
                end
              end
              ST_AHI: next_s.st = ST_ALO;
              ST_ALO: begin
                next_s.st     = ST_WDAT;
                next_s.wp_blk = wp_eff;
              end
              default: next_s.st = ST_WDAT;
            endcase
          end else if (s.bitcnt == 4'h8) begin
            case (s.st)
              ST_DEV: begin
                ok = (s.sh[7:4] == DEV_CODE) && (s.sh[3:1] == sel) &&
                     !s.busy;
                next_s.rw = s.sh[0];
              end
              ST_AHI: begin
                ok = 1'b1;
                next_s.addr[ADDR_W-1:8] = s.sh[ADDR_W-9:0];
              end
              ST_ALO: begin
                ok = 1'b1;
                next_s.addr[7:0] = s.sh;
              end
              default: begin
                ok = !s.wp_blk;
                if (ok) begin
                  next_s.pbuf[s.addr[PW-1:0]]  = s.sh;
                  next_s.pmask[s.addr[PW-1:0]] = 1'b1;
                  next_s.addr[PW-1:0] = s.addr[PW-1:0] + 1'b1;
                end
              end
            endcase
            next_s.ackph = 1'b1;
            next_s.pend  = !ok;
            next_s.hcnt  = HOLD;
            if (!ok) begin
              next_s.st = ST_IGN;
            end
          end
        end
        ST_RDAT: begin
          next_s.hcnt = HOLD;
          if (s.bitcnt < 4'h8) begin
            next_s.pend   = s.tx[3'(4'h7 - s.bitcnt)];
            next_s.bitcnt = s.bitcnt + 4'h1;
          end else begin
            next_s.pend = 1'b1;
            next_s.st   = ST_RACK;
          end
        end
        ST_RACK: begin
          next_s.hcnt = HOLD;
          if (s.macked) begin
            next_s.st     = ST_RDAT;
            next_s.tx     = rd_byte;
            next_s.addr   = s.addr + 1'b1;
            next_s.bitcnt = 4'h1;
            next_s.pend   = rd_byte[7];
          end else begin
            next_s.pend = 1'b1;
            next_s.st   = ST_IGN;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.pend     <= 1'b1;
      s.sda_oe_n <= 1'b1;
      s.pucnt    <= PUW'(PU_CYC);
      s.scl_q    <= 1'b1;
      s.sda_q    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Array, written from the page buffer at the end of a write cycle
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= ERASED_BYTE;
      end
    end else if (do_commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (s.pmask[i]) begin
          mem[{s.addr[ADDR_W-1:PW], PW'(i)}] <= s.pbuf[i];
        end
      end
    end
  end

  // Data pin drives only a constant low level
  assign sda_o      = s.sda_o;
  assign sda_oe_n   = s.sda_oe_n;
  assign ready      = s.ready;
  assign write_busy = s.busy;
endmodule
`default_nettype wire

// ==== design/eei2c_pkg.sv ====
// Shared constants of the two-wire serial memory target
`default_nettype none
package eei2c_pkg;
  // ****************************************************************
  // Array and addressing
  // ****************************************************************
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned PAGE_BYTES  = 32;
  localparam logic [3:0]  DEV_CODE    = 4'ha;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic [2:0]  SEL_NO_PINS = 3'h0;

  // ****************************************************************
  // Clock rates
  // ****************************************************************
  localparam int unsigned CLK_NS      = 8;
  localparam int unsigned LINK_CLK_NS = 64;

  // ****************************************************************
  // Timing, figures and derived cycle counts
  // ****************************************************************
  localparam int unsigned GLITCH_FILTER_WIDTH_NS = 100;
  localparam int unsigned GLITCH_LINK_CYC =
    (GLITCH_FILTER_WIDTH_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  localparam int unsigned POWERUP_READY_DELAY_MS = 1;
  localparam int unsigned POWERUP_READY_CYC =
    POWERUP_READY_DELAY_MS * 1000000 / CLK_NS;
  localparam int unsigned INTERNAL_WRITE_TIME_MS = 5;
  localparam int unsigned INTERNAL_WRITE_CYC =
    INTERNAL_WRITE_TIME_MS * 1000000 / CLK_NS;
  localparam int unsigned OUT_HOLD_NS    = 100;
  localparam int unsigned OUT_HOLD_FP_NS = 50;
  localparam int unsigned OUT_HOLD_CYC =
    (OUT_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OUT_HOLD_FP_CYC =
    (OUT_HOLD_FP_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// ==== design/eei2c_filter.sv ====
// Pin synchroniser and pulse-width filter on the link clock
`default_nettype none
module eei2c_filter
  import eei2c_pkg::*;
#(
  parameter int unsigned HOLD = GLITCH_LINK_CYC
) (
  // Link clock and reset
  input  wire logic link_clk,
  input  wire logic rst_n,
  // Pin and filtered level
  input  wire logic pin,
  output logic      level
);
  localparam int unsigned CW = $clog2(HOLD + 2);

  if (HOLD < 1) begin : g_chk
    $error("eei2c_filter: HOLD must be at least 1");
  end

  typedef struct packed {
    logic [2:0]    sync;
    logic          agreed;
    logic [CW-1:0] cnt;
    logic          level;
  } eei2c_flt_t;

  eei2c_flt_t s;
  eei2c_flt_t next_s;

  always_comb begin
    next_s      = s;
    next_s.sync = {s.sync[1:0], pin};
    if (s.sync[1] == s.sync[2]) begin
      next_s.agreed = s.sync[2];
    end
    // New level only after it outlasts the noise width
    if (s.agreed == s.level) begin
      next_s.cnt = '0;
    end else if (s.cnt == CW'(HOLD)) begin
      next_s.level = s.agreed;
      next_s.cnt   = '0;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{sync: 3'h7, agreed: 1'b1, cnt: '0, level: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
endmodule
`default_nettype wire

// ==== design/eei2c_sync.sv ====
// Level synchroniser into the system clock
`default_nettype none
module eei2c_sync
  import eei2c_pkg::*;
#(
  parameter int unsigned W     = 1,
  parameter bit          AGREE = 1'b0,
  parameter logic [W-1:0] RST  = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous input and synchronised level
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);
  if (W < 1) begin : g_chk
    $error("eei2c_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } eei2c_syn_t;

  eei2c_syn_t s;
  eei2c_syn_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = din;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < W; i++) begin
      if (!AGREE || (s.s2[i] == s.s3[i])) begin
        next_s.out[i] = s.s2[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{s1: RST, s2: RST, s3: RST, out: RST};
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.out;
endmodule
`default_nettype wire

// ==== testbench/eei2c_target_asserts.sv ====
// Concurrent checks on the serial memory target's pins
`default_nettype none
module eei2c_target_asserts
  import eei2c_pkg::*;
#(
  parameter int unsigned PU_CYC = 50,
  parameter int unsigned WR_CYC = 200
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pins and status
  input  wire logic scl_pin,
  input  wire logic sda_o,
  input  wire logic sda_oe_n,
  input  wire logic ready,
  input  wire logic write_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] busy_cnt;
  logic [31:0] pu_cnt;

  // ****************************************************************
  // Cycle counters
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 32'h0;
      pu_cnt   <= 32'h0;
    end else begin
      busy_cnt <= write_busy ? busy_cnt + 32'h1 : 32'h0;
      pu_cnt   <= ready ? pu_cnt : pu_cnt + 32'h1;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_scl_fall;
    $fell(scl_pin);
  endsequence
  sequence s_out_held;
    $stable(sda_oe_n) [*6];
  endsequence
  sequence s_busy_end;
    $fell(write_busy);
  endsequence

  AST_DRIVE_LOW_ONLY: assert property (sda_o == 1'b0)
    else $error("data output value not low");
  AST_PULL_IN_SCL_LOW: assert property ($fell(sda_oe_n) |-> !scl_pin)
    else $error("data pulled low while clock high");
  AST_OUT_HOLD: assert property (s_scl_fall |=> s_out_held)
    else $error("data output changed too soon after clock fall");
  AST_QUIET_UNTIL_READY: assert property (!ready |-> sda_oe_n)
    else $error("data pulled before ready");
  AST_BUSY_RELEASED: assert property (write_busy |-> sda_oe_n)
    else $error("data pulled during write cycle");
  AST_READY_HOLDS: assert property (ready |=> ready)
    else $error("ready dropped without reset");
  AST_READY_DELAY: assert property ($rose(ready) |->
    pu_cnt >= PU_CYC - 1 && pu_cnt <= PU_CYC + 1)
    else $error("power-up delay wrong");
  AST_BUSY_AFTER_STOP: assert property (
    $rose(write_busy) |-> scl_pin)
    else $error("write cycle began with clock low");
  AST_BUSY_LEN: assert property (s_busy_end |->
    busy_cnt >= WR_CYC - 1 && busy_cnt <= WR_CYC + 1)
    else $error("write cycle length wrong");
endmodule
`default_nettype wire

// ==== testbench/eei2c_ctl_model.sv ====
// Two-wire bus controller model facing the serial memory target
`default_nettype none
module eei2c_ctl_model #(
  parameter int unsigned Q = 100
) (
  // Clock
  input  wire logic       clk,
  // Bus lines
  output var  logic       scl,
  output var  logic       sda_oe_n,
  input  wire logic       sda,
  // Observed results
  output var  logic       res_valid,
  output var  logic [7:0] res_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl       = 1'b1;
    sda_oe_n  = 1'b1;
    res_valid = 1'b0;
    res_data  = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic report(input logic [7:0] v);
    res_data  <= v;
    res_valid <= 1'b1;
    tick(1);
    res_valid <= 1'b0;
  endtask

  // One bit: data set mid low, sampled mid high
  task automatic bit_io(input logic b, input logic g, output logic v);
    tick(Q);
    sda_oe_n <= b;
    tick(Q);
    scl <= 1'b1;
    if (g) begin
      // Short pulses on both lines
      tick(60);
      scl <= 1'b0;
      tick(10);
      scl <= 1'b1;
      tick(10);
      sda_oe_n <= 1'b0;
      tick(10);
      sda_oe_n <= b;
      tick(Q - 90);
    end else begin
      tick(Q);
    end
    v = sda;
    tick(Q);
    scl <= 1'b0;
  endtask

  task automatic start;
    tick(Q);
    sda_oe_n <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_oe_n <= 1'b0;
    tick(Q);
    scl <= 1'b0;
  endtask

  task automatic stop;
    tick(Q);
    sda_oe_n <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_oe_n <= 1'b1;
    tick(Q);
  endtask

  task automatic put_byte(input logic [7:0] b, input logic g);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], g && i == 7, v);
    end
    bit_io(1'b1, 1'b0, v);
    report({7'h0, v});
  endtask

  task automatic get_byte(input logic last);
    logic [7:0] d;
    logic       v;
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, 1'b0, v);
      d = {d[6:0], v};
    end
    report(d);
    bit_io(last, 1'b0, v);
  endtask
endmodule
`default_nettype wire

// ==== testbench/eei2c_target_tb.sv ====
// Self-checking bench for the serial memory target
`default_nettype none
module eei2c_target_tb
  import eei2c_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PU = 50;
  localparam int unsigned WR = 6000;
  logic        clk, link_clk, rst_n, scl, ctl_oe_n, sda, sda_o, dut_oe_n;
  logic        wp, ready, busy, res_valid;
  logic [2:0]  sel;
  logic [7:0]  res_data, d0, d1;
  logic [11:0] addr;
  logic [7:0]  exp_q[$];
  int          err_total, n_tests, seed;

  // Pull-up on the shared data wire
  assign sda = ctl_oe_n & dut_oe_n;

  eei2c_target #(.PU_CYC(PU), .WR_CYC(WR)) dut (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_pin(scl),
    .sda_pin(sda), .sda_o(sda_o), .sda_oe_n(dut_oe_n),
    .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
    .addr_select_bit2(sel[2]), .wp_pin(wp), .ready(ready),
    .write_busy(busy)
  );
  eei2c_ctl_model #(.Q(100)) ctl (
    .clk(clk), .scl(scl), .sda_oe_n(ctl_oe_n), .sda(sda),
    .res_valid(res_valid), .res_data(res_data)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    // First rise falls inside reset so the pin filters start clean
    forever begin
      link_clk = ~link_clk;
      #32;
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] dev(input logic rw);
    return {DEV_CODE, sel, rw};
  endfunction

  task automatic send(input logic [7:0] b, input logic [7:0] ack,
                      input logic g);
    exp_q.push_back(ack);
    ctl.put_byte(b, g);
  endtask

  task automatic recv(input logic [7:0] e, input logic last);
    exp_q.push_back(e);
    ctl.get_byte(last);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    check("write cycle end", {7'h0, busy}, 8'h00);
  endtask

  // Oldest note against each observed result
  always @(posedge clk) begin
    if (res_valid === 1'b1) begin
      if (exp_q.size() > 0) begin
        check("bus result", res_data, exp_q.pop_front());
      end else begin
        check("unexpected result", res_data, 8'hxx);
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    test_done();
  end

  initial begin
    seed = 68;
    err_total = 0;
    n_tests = 0;
    rst_n = 1'b0;
    wp = 1'b0;
    sel = 3'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (PU - 4) @(negedge clk);
    check("ready early", {7'h0, ready}, 8'h00);
    repeat (8) @(negedge clk);
    check("ready", {7'h0, ready}, 8'h01);
    check("drive value", {7'h0, sda_o}, 8'h00);
    @(posedge clk);
    ctl.start();
    send({DEV_CODE, 3'h5, 1'b0}, 8'h01, 1'b0);
    ctl.start();
    send(dev(1'b0), 8'h00, 1'b0);
    ctl.stop();
    sel <= 3'($random(seed));
    addr = 12'($random(seed));
    addr[4:0] = 5'h0e;
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    ctl.start();
    send(dev(1'b0), 8'h00, 1'b1);
    send({4'h0, addr[11:8]}, 8'h00, 1'b0);
    send(addr[7:0], 8'h00, 1'b0);
    send(d0, 8'h00, 1'b0);
    send(d1, 8'h00, 1'b0);
    ctl.stop();
    @(negedge clk);
    check("write busy", {7'h0, busy}, 8'h01);
    ctl.start();
    send(dev(1'b0), 8'h01, 1'b0);
    ctl.stop();
    wait_idle();
    @(posedge clk);
    wp <= 1'b1;
    ctl.start();
    send(dev(1'b0), 8'h00, 1'b0);
    send({4'h0, addr[11:8]}, 8'h00, 1'b0);
    send(addr[7:0], 8'h00, 1'b0);
    send(~d0, 8'h01, 1'b0);
    ctl.stop();
    wait_idle();
    @(posedge clk);
    wp <= 1'b0;
    ctl.start();
    send(dev(1'b0), 8'h00, 1'b0);
    send({4'h0, addr[11:8]}, 8'h00, 1'b0);
    send(addr[7:0], 8'h00, 1'b0);
    ctl.start();
    send(dev(1'b1), 8'h00, 1'b0);
    recv(d0, 1'b0);
    recv(d1, 1'b0);
    recv(ERASED_BYTE, 1'b1);
    ctl.stop();
    repeat (10) @(negedge clk);
    check("results left", 8'(exp_q.size()), 8'h00);
    check("drive value", {7'h0, sda_o}, 8'h00);
    test_done();
  end
endmodule

bind eei2c_target eei2c_target_asserts #(
  .PU_CYC(PU_CYC),
  .WR_CYC(WR_CYC)
) u_chk (
  .clk(clk), .rst_n(rst_n), .scl_pin(scl_pin), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .ready(ready), .write_busy(write_busy)
);
`default_nettype wire
